/* src/hsec_pkg.sv */
package hsec_pkg;
	// register byte offsets on the avalon slave
	localparam logic [5:0] CTRL_OFF = 6'h00;
	localparam logic [5:0] CFG_OFF = 6'h04;
	localparam logic [5:0] PEND_DIR_OFF = 6'h08;
	localparam logic [5:0] PEND_CNT_OFF = 6'h0C;
	localparam logic [5:0] PEND_REF_OFF = 6'h10;
	localparam logic [5:0] PEND_PER_OFF = 6'h14;
	localparam logic [5:0] COUNT_OFF = 6'h18;
	localparam logic [5:0] REF_OFF = 6'h1C;
	localparam logic [5:0] FREQ_OFF = 6'h20;
	localparam logic [5:0] STAT_OFF = 6'h24;
	localparam logic [5:0] IRQ_STAT_OFF = 6'h28;
	localparam logic [5:0] IRQ_EN_OFF = 6'h2C;
	localparam logic [5:0] IRQ_CLR_OFF = 6'h30;
	localparam logic [5:0] FILT_OFF = 6'h34;
	// control register bits: request strobe plus four load flags
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_DIR_BIT = 1;
	localparam int CTRL_CNT_BIT = 2;
	localparam int CTRL_REF_BIT = 3;
	localparam int CTRL_PER_BIT = 4;
	// interrupt status bit positions
	localparam int IRQ_EQ_BIT = 0;
	localparam int IRQ_RST_BIT = 1;
	localparam int IRQ_DIR_BIT = 2;
	// filter time: 6.4 ms default at 200 MHz
	localparam int CLK_MHZ = 200;
	localparam int FILT_DEF_US = 6400;
	localparam int FILT_DEF_CYC = FILT_DEF_US * CLK_MHZ;
	// frequency periods in microseconds (0.01, 0.1, 1.0 s)
	localparam int PER_10MS_US = 10000;
	localparam int PER_100MS_US = 100000;
	localparam int PER_1S_US = 1000000;
	localparam int US_CYC = CLK_MHZ;
	// reset values and the illegal-period status code
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [15:0] STATUS_OK = 16'h0000;
	localparam logic [15:0] STATUS_BAD_PER = 16'h80B1;

	typedef enum logic [1:0] {
		HSEC_SINGLE_INT = 2'h0,
		HSEC_SINGLE_EXT = 2'h1,
		HSEC_UPDOWN = 2'h3,
		HSEC_QUAD = 2'h2
	} hsec_mode_e;

	typedef enum logic [1:0] {
		HSEC_PER_10MS = 2'h0,
		HSEC_PER_100MS = 2'h1,
		HSEC_PER_1S = 2'h2
	} hsec_per_e;

	// configuration register layout
	typedef struct packed {
		logic [22:0] rsv;
		logic reset_en; // bit 8: external reset input used
		logic freq_mode; // bit 7: measure frequency instead of count
		logic [1:0] irq_route; // bits 6:5: spare interrupt assignment
		logic [1:0] in_map; // bits 4:3: input connection swap/invert
		logic init_dir; // bit 2: 1 = down
		hsec_mode_e mode; // bits 1:0
	} hsec_cfg_s;

	// pending values of one control request
	typedef struct packed {
		logic dir;
		logic [31:0] cnt;
		logic [31:0] ref_val;
		hsec_per_e per;
	} hsec_pend_s;

	// filtered input pins
	typedef struct packed {
		logic a;
		logic b;
		logic rst;
	} hsec_pins_s;
endpackage : hsec_pkg

/* src/hsec_sync_filt.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser followed by a stability filter
module hsec_sync_filt #(
	parameter int CW = 24
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset
	input wire logic pin, // raw pin
	input wire logic [CW-1:0] filt_cyc, // cycles a level must be stable
	output logic q // filtered level
);
	logic s1_reg;
	logic s2_reg;
	logic [CW-1:0] cnt_reg;

	// first flop only feeds the second, to settle metastability
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
		end
	end

	// accept a new level only once it held for filt_cyc cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			q <= 1'b0;
		end else if (s2_reg == q) begin
			cnt_reg <= '0;
		end else if (cnt_reg >= filt_cyc) begin
			q <= s2_reg;
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule : hsec_sync_filt
`default_nettype wire

/* src/hsec_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// turns filtered pins into count-up / count-down pulses
module hsec_decode (
	input wire logic clk, // system clock
	input wire logic rst_n, // synchronised reset
	input wire hsec_pkg::hsec_mode_e mode, // input type
	input wire logic soft_dir, // internal direction, 1 = down
	input wire logic a, // clock / clock up / phase A
	input wire logic b, // direction / clock down / phase B
	output logic up, // one-cycle count up pulse
	output logic dn // one-cycle count down pulse
);
	logic a_reg;
	logic b_reg;
	logic a_rise;
	logic b_rise;
	logic a_chg;
	logic b_chg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_reg <= 1'b0;
			b_reg <= 1'b0;
		end else begin
			a_reg <= a;
			b_reg <= b;
		end
	end

	assign a_rise = a & ~a_reg;
	assign b_rise = b & ~b_reg;
	assign a_chg = a ^ a_reg;
	assign b_chg = b ^ b_reg;

	// four input types; quadrature counts every edge of one phase alone, none when both change together
	always_comb begin
		up = 1'b0;
		dn = 1'b0;
		case (mode)
			hsec_pkg::HSEC_SINGLE_INT: begin
				up = a_rise & ~soft_dir;
				dn = a_rise & soft_dir;
			end
			hsec_pkg::HSEC_SINGLE_EXT: begin
				up = a_rise & ~b;
				dn = a_rise & b;
			end
			hsec_pkg::HSEC_UPDOWN: begin
				up = a_rise & ~b_rise;
				dn = b_rise & ~a_rise;
			end
			hsec_pkg::HSEC_QUAD: begin
				up = (a_chg & (a ^ b)) | (b_chg & ~(a ^ b));
				dn = (a_chg & ~(a ^ b)) | (b_chg & (a ^ b));
				if (a_chg & b_chg) begin
					up = 1'b0;
					dn = 1'b0;
				end
			end
			default: begin
				up = 1'b0;
				dn = 1'b0;
			end
		endcase
	end
endmodule : hsec_decode
`default_nettype wire

/* src/hsec_counter.sv */
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - request loads each value whose flag is 1
// - all flagged values applied in one request
// - flag at 0 leaves value unchanged
// - interrupt when count equals reference
// - interrupts on external reset and direction change
// - count read at its own register
// - read returns exact count, counting continues
// - frequency measurement with loadable period
// - configuration selects mode, inputs, interrupt, function
// - digital input filter, default 6.4 ms
// - built-in channels 100/80 and 30/20 kHz
// - expansion channels 200/160 kHz
// - periods 0.01/0.1/1 s, result in hertz
// - external reset clears and holds count zero
// - four input types incl. quadrature
module hsec_counter #(
	parameter int FILT_DEF = hsec_pkg::FILT_DEF_CYC, // default filter cycles
	parameter int US_CYC = hsec_pkg::US_CYC // cycles per microsecond
) (
	input wire logic clk, // 200 MHz system clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic [5:0] avs_address, // byte address
	input wire logic avs_read, // read strobe
	input wire logic avs_write, // write strobe
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic pin_a, // clock / clock up / phase A
	input wire logic pin_b, // direction / clock down / phase B
	input wire logic pin_rst, // external reset / home
	output logic irq // level interrupt
);
	logic rs1_reg;
	logic rst_n;
	// reset released through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rs1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1_reg <= 1'b1;
			rst_n <= rs1_reg;
		end
	end

	hsec_pkg::hsec_cfg_s cfg_reg;
	hsec_pkg::hsec_pend_s pend_reg;
	logic [4:0] ctrl_reg;
	logic busy_reg;
	logic [15:0] status_reg;
	logic [23:0] filt_reg;
	logic dir_reg;
	logic [31:0] count_reg;
	logic [31:0] ref_reg;
	hsec_pkg::hsec_per_e per_reg;
	logic [31:0] freq_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_en_reg;
	logic rd_done_reg;
	hsec_pkg::hsec_pins_s pins;
	logic raw_a;
	logic raw_b;
	logic up;
	logic dn;
	logic ext_rst;
	logic ext_rst_reg;
	logic wr_ok;
	logic go;
	logic [31:0] count_next;
	logic [2:0] irq_set;

	// byte-enable merge, used for the configuration, pending count/reference and filter registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction : merge

	// microseconds of a period code, cycles derived from the clock rate
	function automatic logic [31:0] per_cycles(input hsec_pkg::hsec_per_e p);
		case (p)
			hsec_pkg::HSEC_PER_10MS: per_cycles = 32'(hsec_pkg::PER_10MS_US * US_CYC);
			hsec_pkg::HSEC_PER_100MS: per_cycles = 32'(hsec_pkg::PER_100MS_US * US_CYC);
			default: per_cycles = 32'(hsec_pkg::PER_1S_US * US_CYC);
		endcase
	endfunction : per_cycles

	// input connection option: swap A/B on bit 0, invert reset on bit 1
	assign raw_a = cfg_reg.in_map[0] ? pin_b : pin_a;
	assign raw_b = cfg_reg.in_map[0] ? pin_a : pin_b;

	// per-pin sync and filter; filter time sets max accepted rate
	hsec_sync_filt #(.CW(24)) u_fa (
		.clk(clk),
		.rst_n(rst_n),
		.pin(raw_a),
		.filt_cyc(filt_reg),
		.q(pins.a)
	);
	hsec_sync_filt #(.CW(24)) u_fb (
		.clk(clk),
		.rst_n(rst_n),
		.pin(raw_b),
		.filt_cyc(filt_reg),
		.q(pins.b)
	);
	hsec_sync_filt #(.CW(24)) u_fr (
		.clk(clk),
		.rst_n(rst_n),
		.pin(pin_rst ^ cfg_reg.in_map[1]),
		.filt_cyc(filt_reg),
		.q(pins.rst)
	);

	hsec_decode u_dec (
		.clk(clk),
		.rst_n(rst_n),
		.mode(cfg_reg.mode),
		.soft_dir(dir_reg),
		.a(pins.a),
		.b(pins.b),
		.up(up),
		.dn(dn)
	);

	// reset input only acts in counting mode
	assign ext_rst = pins.rst & cfg_reg.reset_en & ~cfg_reg.freq_mode;
	assign wr_ok = avs_write & ~avs_waitrequest;
	assign go = ctrl_reg[hsec_pkg::CTRL_GO_BIT];

	// writes answer at once; reads take one extra cycle
	assign avs_waitrequest = avs_read & ~rd_done_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rd_done_reg <= 1'b0;
		else rd_done_reg <= avs_read & ~rd_done_reg;
	end

	// readback: count sampled at the read, unaffected afterwards
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= '0;
		end else if (avs_read & ~rd_done_reg) begin
			case (avs_address)
				hsec_pkg::CTRL_OFF: avs_readdata <= {27'h0, ctrl_reg};
				hsec_pkg::CFG_OFF: avs_readdata <= cfg_reg;
				hsec_pkg::PEND_DIR_OFF: avs_readdata <= {31'h0, pend_reg.dir};
				hsec_pkg::PEND_CNT_OFF: avs_readdata <= pend_reg.cnt;
				hsec_pkg::PEND_REF_OFF: avs_readdata <= pend_reg.ref_val;
				hsec_pkg::PEND_PER_OFF: avs_readdata <= {30'h0, pend_reg.per};
				hsec_pkg::COUNT_OFF: avs_readdata <= count_reg;
				hsec_pkg::REF_OFF: avs_readdata <= ref_reg;
				hsec_pkg::FREQ_OFF: avs_readdata <= freq_reg;
				hsec_pkg::STAT_OFF: avs_readdata <= {14'h0, dir_reg, busy_reg, status_reg};
				hsec_pkg::IRQ_STAT_OFF: avs_readdata <= {29'h0, irq_stat_reg};
				hsec_pkg::IRQ_EN_OFF: avs_readdata <= {29'h0, irq_en_reg};
				hsec_pkg::FILT_OFF: avs_readdata <= {8'h0, filt_reg};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// configuration, pending values, filter time, interrupt enables
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= hsec_pkg::CFG_RST;
			pend_reg <= '0;
			filt_reg <= 24'(FILT_DEF);
			irq_en_reg <= '0;
		end else if (wr_ok) begin
			case (avs_address)
				hsec_pkg::CFG_OFF: cfg_reg <= merge(cfg_reg, avs_writedata, avs_byteenable);
				hsec_pkg::PEND_DIR_OFF: pend_reg.dir <= avs_writedata[0];
				hsec_pkg::PEND_CNT_OFF: pend_reg.cnt <= merge(pend_reg.cnt, avs_writedata, avs_byteenable);
				hsec_pkg::PEND_REF_OFF:
					pend_reg.ref_val <= merge(pend_reg.ref_val, avs_writedata, avs_byteenable);
				hsec_pkg::PEND_PER_OFF: pend_reg.per <= hsec_pkg::hsec_per_e'(avs_writedata[1:0]);
				hsec_pkg::FILT_OFF: filt_reg <= 24'(merge({8'h0, filt_reg}, avs_writedata, avs_byteenable));
				hsec_pkg::IRQ_EN_OFF: irq_en_reg <= avs_writedata[2:0];
				default: ;
			endcase
		end
	end

	// control request: latched on write, applied next cycle while busy
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= '0;
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= wr_ok & (avs_address == hsec_pkg::CTRL_OFF)
				& avs_writedata[hsec_pkg::CTRL_GO_BIT];
			if (wr_ok & (avs_address == hsec_pkg::CTRL_OFF)) ctrl_reg <= avs_writedata[4:0];
			else ctrl_reg[hsec_pkg::CTRL_GO_BIT] <= 1'b0;
		end
	end

	// status word: zero on success, error code for an illegal period
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= hsec_pkg::STATUS_OK;
		end else if (go) begin
			if (ctrl_reg[hsec_pkg::CTRL_PER_BIT] && pend_reg.per == 2'h3)
				status_reg <= hsec_pkg::STATUS_BAD_PER;
			else status_reg <= hsec_pkg::STATUS_OK;
		end
	end

	// direction, reference, period: each loaded on a request only if its flag is set; direction also on a configuration write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_reg <= 1'b0;
			ref_reg <= '0;
			per_reg <= hsec_pkg::HSEC_PER_10MS;
		end else if (go) begin
			if (ctrl_reg[hsec_pkg::CTRL_DIR_BIT]) dir_reg <= pend_reg.dir;
			if (ctrl_reg[hsec_pkg::CTRL_REF_BIT]) ref_reg <= pend_reg.ref_val;
			if (ctrl_reg[hsec_pkg::CTRL_PER_BIT] && pend_reg.per != 2'h3)
				per_reg <= pend_reg.per;
		end else if (wr_ok & (avs_address == hsec_pkg::CFG_OFF) & avs_byteenable[0]) begin
			dir_reg <= avs_writedata[2]; // initial direction follows configuration
		end
	end

	// counter: external reset wins, then load, then pulses
	always_comb begin
		count_next = count_reg;
		if (ext_rst) count_next = '0;
		else if (go & ctrl_reg[hsec_pkg::CTRL_CNT_BIT]) count_next = pend_reg.cnt;
		else if (up) count_next = count_reg + 32'h0000_0001;
		else if (dn) count_next = count_reg - 32'h0000_0001;
	end

	// only counting mode steers the count register from pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) count_reg <= '0;
		else if (!cfg_reg.freq_mode || ext_rst || go) count_reg <= count_next;
	end

	// frequency: pulses over one period, scaled to hertz
	logic [31:0] per_cnt_reg;
	logic [31:0] acc_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			per_cnt_reg <= '0;
			acc_reg <= '0;
			freq_reg <= '0;
		end else if (!cfg_reg.freq_mode) begin
			per_cnt_reg <= '0;
			acc_reg <= '0;
		end else if (per_cnt_reg >= per_cycles(per_reg) - 32'h0000_0001) begin
			per_cnt_reg <= '0;
			acc_reg <= '0;
			case (per_reg)
				hsec_pkg::HSEC_PER_10MS: freq_reg <= 32'(acc_reg * 100);
				hsec_pkg::HSEC_PER_100MS: freq_reg <= 32'(acc_reg * 10);
				default: freq_reg <= acc_reg;
			endcase
		end else begin
			per_cnt_reg <= per_cnt_reg + 32'h0000_0001;
			if (up | dn) acc_reg <= acc_reg + 32'h0000_0001;
		end
	end

	// events: equal-to-reference, reset edge, direction change
	logic last_dn_reg;
	logic eq_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_rst_reg <= 1'b0;
			last_dn_reg <= 1'b0;
			eq_reg <= 1'b0;
		end else begin
			ext_rst_reg <= ext_rst;
			eq_reg <= (count_reg == ref_reg);
			if (up) last_dn_reg <= 1'b0;
			else if (dn) last_dn_reg <= 1'b1;
		end
	end

	assign irq_set[hsec_pkg::IRQ_EQ_BIT] = (count_reg == ref_reg) & ~eq_reg
		& ~cfg_reg.freq_mode;
	assign irq_set[hsec_pkg::IRQ_RST_BIT] = ext_rst & ~ext_rst_reg;
	assign irq_set[hsec_pkg::IRQ_DIR_BIT] = (up & last_dn_reg) | (dn & ~last_dn_reg)
		| (go & ctrl_reg[hsec_pkg::CTRL_DIR_BIT] & (pend_reg.dir != dir_reg));

	// sticky status; a set in the clear cycle wins, software reloads from the handler
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) irq_stat_reg <= '0;
		else if (wr_ok & (avs_address == hsec_pkg::IRQ_CLR_OFF))
			irq_stat_reg <= (irq_stat_reg & ~avs_writedata[2:0]) | irq_set;
		else irq_stat_reg <= irq_stat_reg | irq_set;
	end

	// interrupt routing bit 0 of irq_route masks all when set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) irq <= 1'b0;
		else irq <= |(irq_stat_reg & irq_en_reg) & ~cfg_reg.irq_route[0];
	end
endmodule : hsec_counter
`default_nettype wire

/* bench/hsec_counter_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// bus and interrupt checks seen from the top ports only
module hsec_counter_chk #(
	parameter int FILT_DEF = 2, // filter cycles
	parameter int US_CYC = 1 // cycles per microsecond
) (
	input wire logic clk, // clock
	input wire logic arst_n, // reset, active low
	input wire logic [5:0] avs_address, // byte address
	input wire logic avs_read, // read strobe
	input wire logic avs_write, // write strobe
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	input wire logic [31:0] avs_readdata, // read data
	input wire logic avs_waitrequest, // stall
	input wire logic pin_a, // input a
	input wire logic pin_b, // input b
	input wire logic pin_rst, // external reset input
	input wire logic irq // interrupt
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// a read stalls exactly one cycle, so polling software never hangs
	chk_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read stalled more than one cycle");
	chk_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
		else $error("write stalled");
	chk_idle_no_wait: assert property (!avs_read |-> !avs_waitrequest)
		else $error("stall without a read");
	chk_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
		avs_address > hsec_pkg::FILT_OFF |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_irq_disable: assert property (avs_write && avs_address == hsec_pkg::IRQ_EN_OFF &&
		avs_writedata[2:0] == 3'h0 |-> ##2 !irq)
		else $error("irq high with all enables off");
	// status is sticky: only a register write may take the line down
	chk_irq_fall_cause: assert property ($fell(irq) |-> $past(avs_write, 2))
		else $error("irq dropped without a write");
	chk_cfg_mask: assert property (avs_write && avs_address == hsec_pkg::CFG_OFF &&
		avs_byteenable[0] && avs_writedata[5] |-> ##2 !irq [*3])
		else $error("irq not masked by configuration");
	chk_reset_quiet: assert property ($rose(arst_n) |-> !irq && avs_readdata == 32'h0 ##1 !irq)
		else $error("outputs not quiet after reset");
	cover property (avs_read && !avs_waitrequest && avs_address == hsec_pkg::FREQ_OFF);
	cover property ($rose(irq));
	cover property (avs_write && avs_address == hsec_pkg::CTRL_OFF && avs_writedata[0]);
endmodule : hsec_counter_chk
bind hsec_counter hsec_counter_chk #(.FILT_DEF(FILT_DEF), .US_CYC(US_CYC)) u_chk (
	.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_a(pin_a),
	.pin_b(pin_b), .pin_rst(pin_rst), .irq(irq)
);
`default_nettype wire

/* bench/hsec_pulse_src.sv */
`timescale 1ns/1ps
`default_nettype none
// pulse source in place of a shaft encoder, free of the counter clock
module hsec_pulse_src (
	output logic pin_a, // clock / clock up / phase A
	output logic pin_b, // direction / clock down / phase B
	output logic pin_rst // home / reset input
);
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
		pin_rst = 1'b0;
	end
	// kind 0 clocks a with b as level, 1 clocks b, 2 a leads b, 3 b leads a
	task automatic burst(input int n, input int kind, input logic lvl, input realtime half);
		#1.3; // odd offset keeps edges off the counter clock
		if (kind == 0)
			pin_b = lvl;
		for (int i = 0; i < n; i++) begin
			for (int ph = 0; ph < ((kind < 2) ? 2 : 4); ph++) begin
				if (kind == 0 || (kind == 2 && ph % 2 == 0) || (kind == 3 && ph % 2 == 1))
					pin_a = ~pin_a;
				else
					pin_b = ~pin_b;
				#half;
			end
		end
		#200; // let synchroniser and filter drain
	endtask : burst
	task automatic home(input logic on);
		pin_rst = on;
		#100;
	endtask : home
endmodule : hsec_pulse_src
`default_nettype wire

/* bench/hsec_counter_test.sv */
`timescale 1ns/1ps
`default_nettype none
module hsec_counter_test;
	localparam int FILT = 2; // short filter keeps pulse trains brief
	localparam int FHZ = 100 * 10000 / 16; // 16-cycle pulses over a 10 ms window
	logic clk, arst_n, avs_read, avs_write, avs_waitrequest, pin_a, pin_b, pin_rst, irq, wq;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rq, v;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;

	hsec_counter #(.FILT_DEF(FILT), .US_CYC(1)) DUT (.clk(clk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pin_a(pin_a), .pin_b(pin_b), .pin_rst(pin_rst),
		.irq(irq));
	hsec_pulse_src src (.pin_a(pin_a), .pin_b(pin_b), .pin_rst(pin_rst));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// answers sampled mid-cycle, clear of the edge that updates them
	always @(negedge clk) begin
		wq <= avs_waitrequest;
		rq <= avs_readdata;
	end
	// hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 200000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic conclude;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// one avalon transfer, held until waitrequest is seen low
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= ~rd;
		do @(posedge clk); while (wq);
		v = rq;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : xfer
	task automatic rchk(input logic [5:0] a, input logic [31:0] exp, input string what);
		xfer(1'b1, a, 32'h0);
		check(what, v, exp);
	endtask : rchk
	task automatic load(input logic [31:0] c, input logic [31:0] r, input logic [31:0] fl);
		xfer(1'b0, hsec_pkg::PEND_CNT_OFF, c);
		xfer(1'b0, hsec_pkg::PEND_REF_OFF, r);
		xfer(1'b0, hsec_pkg::CTRL_OFF, fl);
	endtask : load
	task automatic irq_is(input logic exp);
		repeat (3) @(posedge clk);
		check("irq", {31'h0, irq}, {31'h0, exp});
	endtask : irq_is
	task automatic t_regs;
		rchk(hsec_pkg::CFG_OFF, hsec_pkg::CFG_RST, "cfg");
		rchk(hsec_pkg::FILT_OFF, 32'(FILT), "filter");
		rchk(hsec_pkg::COUNT_OFF, 32'h0, "count");
		rchk(6'h3C, 32'h0, "unmapped");
		rchk(hsec_pkg::STAT_OFF, {16'h0, hsec_pkg::STATUS_OK}, "status");
	endtask : t_regs
	task automatic t_load;
		load(32'h64, 32'h69, 32'h0D);
		rchk(hsec_pkg::COUNT_OFF, 32'h64, "count");
		rchk(hsec_pkg::REF_OFF, 32'h69, "ref");
		load(32'h7, 32'h9, 32'h09);
		rchk(hsec_pkg::COUNT_OFF, 32'h64, "count kept");
		rchk(hsec_pkg::REF_OFF, 32'h9, "ref");
	endtask : t_load
	task automatic t_single;
		xfer(1'b0, hsec_pkg::CFG_OFF, 32'h0);
		load(32'h0, 32'hFFFF, 32'h05);
		src.burst(5, 0, 1'b0, 40.0);
		rchk(hsec_pkg::COUNT_OFF, 32'h5, "count up");
		xfer(1'b0, hsec_pkg::PEND_DIR_OFF, 32'h1);
		xfer(1'b0, hsec_pkg::CTRL_OFF, 32'h03);
		src.burst(2, 0, 1'b0, 40.0);
		rchk(hsec_pkg::COUNT_OFF, 32'h3, "count down");
		xfer(1'b1, hsec_pkg::IRQ_STAT_OFF, 32'h0);
		check("dir event", v & 32'h4, 32'h4);
	endtask : t_single
	// forward then reverse must come back to zero, for external direction, quadrature and up/down inputs
	task automatic t_pair(input logic [31:0] cfg, input int kf, input int kr);
		xfer(1'b0, hsec_pkg::CFG_OFF, cfg);
		load(32'h0, 32'hFFFF, 32'h05);
		src.burst(3, kf, 1'b0, 40.0);
		xfer(1'b1, hsec_pkg::COUNT_OFF, 32'h0);
		check("moved", {31'h0, (v != 32'h0)}, 32'h1);
		src.burst(3, kr, 1'b1, 40.0);
		rchk(hsec_pkg::COUNT_OFF, 32'h0, "returned");
	endtask : t_pair
	task automatic t_irq;
		xfer(1'b0, hsec_pkg::CFG_OFF, 32'h0);
		xfer(1'b0, hsec_pkg::IRQ_CLR_OFF, 32'h7);
		xfer(1'b0, hsec_pkg::IRQ_EN_OFF, 32'h1);
		xfer(1'b0, hsec_pkg::PEND_DIR_OFF, 32'h0);
		load(32'h0, 32'h2, 32'h0F);
		src.burst(2, 0, 1'b0, 40.0);
		irq_is(1'b1);
		load(32'h0, 32'h4, 32'h09);
		xfer(1'b0, hsec_pkg::IRQ_CLR_OFF, 32'h1);
		irq_is(1'b0);
		src.burst(2, 0, 1'b0, 40.0);
		irq_is(1'b1);
		xfer(1'b0, hsec_pkg::CFG_OFF, 32'h20);
		irq_is(1'b0);
		xfer(1'b0, hsec_pkg::CFG_OFF, 32'h0);
		irq_is(1'b1);
		xfer(1'b0, hsec_pkg::IRQ_EN_OFF, 32'h0);
		irq_is(1'b0);
	endtask : t_irq
	task automatic t_home;
		xfer(1'b0, hsec_pkg::IRQ_CLR_OFF, 32'h7);
		xfer(1'b0, hsec_pkg::IRQ_EN_OFF, 32'h2);
		xfer(1'b0, hsec_pkg::CFG_OFF, 32'h100);
		src.home(1'b1);
		src.burst(3, 0, 1'b0, 40.0);
		rchk(hsec_pkg::COUNT_OFF, 32'h0, "held count");
		irq_is(1'b1);
		src.home(1'b0);
		src.burst(2, 0, 1'b0, 40.0);
		rchk(hsec_pkg::COUNT_OFF, 32'h2, "count after home");
	endtask : t_home
	task automatic t_filter;
		xfer(1'b0, hsec_pkg::CFG_OFF, 32'h0);
		xfer(1'b0, hsec_pkg::FILT_OFF, 32'h14);
		load(32'h0, 32'hFFFF, 32'h05);
		src.burst(3, 0, 1'b0, 25.0);
		rchk(hsec_pkg::COUNT_OFF, 32'h0, "glitches");
		src.burst(3, 0, 1'b0, 200.0);
		rchk(hsec_pkg::COUNT_OFF, 32'h3, "slow pulses");
		xfer(1'b0, hsec_pkg::FILT_OFF, 32'(FILT));
	endtask : t_filter
	task automatic t_freq;
		xfer(1'b0, hsec_pkg::CFG_OFF, 32'h80);
		xfer(1'b0, hsec_pkg::PEND_PER_OFF, 32'h3);
		xfer(1'b0, hsec_pkg::CTRL_OFF, 32'h11);
		xfer(1'b1, hsec_pkg::STAT_OFF, 32'h0);
		check("bad period", {16'h0, v[15:0]}, {16'h0, hsec_pkg::STATUS_BAD_PER});
		xfer(1'b0, hsec_pkg::PEND_PER_OFF, 32'h0);
		xfer(1'b0, hsec_pkg::CTRL_OFF, 32'h11);
		xfer(1'b1, hsec_pkg::STAT_OFF, 32'h0);
		check("period ok", {16'h0, v[15:0]}, {16'h0, hsec_pkg::STATUS_OK});
		fork
			src.burst(1900, 0, 1'b0, 40.0);
			begin
				repeat (25000) @(posedge clk);
				xfer(1'b1, hsec_pkg::FREQ_OFF, 32'h0);
			end
		join
		check("freq", {31'h0, (v >= 32'(FHZ - 100) && v <= 32'(FHZ + 100))}, 32'h1);
	endtask : t_freq
	initial begin
		arst_n = 1'b0;
		avs_address = 6'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_load();
		t_single();
		t_pair(32'h1, 0, 0);
		t_pair(32'h2, 2, 3);
		t_pair(32'h3, 0, 1);
		t_irq();
		t_home();
		t_filter();
		t_freq();
		conclude();
	end
endmodule : hsec_counter_test
`default_nettype wire
